// >>> core/uts_tx_sync_timer.sv
// Transmit synchronisation and timer clock logic of one uart channel
// What this block does
// - Four-bit select picks command 0xE0 plus n
// - Global command bytes reach every uart; decode E0-EF
// - Transmission start is start bit falling edge
// - Sync enabled: start on trigger, only with data
// - Setting sync enable forces transmitter disable high
// - Sync disabled: no trigger starts transmission
// - Auto-disable after FIFO drains; new data waits
// - Trigger delay bit adds programmed delay first
// - Delay is 16 bits of bit intervals
// - Clock replica routed to this uart's GPIO
// - Timer divisor is 15 bits over two registers
// - Timer frequency is clock over 1024 times divisor
// - Timer fed by fractional generator output clock
// - Zero divisor stops the timer clock
// - Timer clock drives GPIO at 50% duty
`timescale 1ns/1ns
module uts_tx_sync_timer #(
    parameter logic [7:0] REVISION_ID = 8'h5a  // Arbitrary value
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire uts_pkg::uts_reg_req_t regReq,
    input  wire logic                  baudTick,
    input  wire logic                  bitTick,
    input  wire logic                  txFifoEmpty,
    input  wire logic                  txLineIn,
    input  wire logic                  sysClkReplica,
    output logic [7:0]                 regRdata,
    output logic                       txDisableForce,
    output logic                       txDisableRelease,
    output logic                       txRun,
    output logic                       syncStarted,
    output logic                       sysClkGpio,
    output logic                       sysClkGpioEn,
    output logic                       timerGpio,
    output logic                       timerGpioEn,
    output logic [1:0]                 syncState
);
    import uts_pkg::*;

    // =========================================================
    // Registers
    uts_sync_ctrl_t ctrl_q;
    logic [7:0]     delayLow_q;
    logic [7:0]     delayHigh_q;
    logic [7:0]     timerLow_q;
    logic [7:0]     timerHigh_q;
    uts_state_t     state_q;
    logic [15:0]    delayCnt_q;
    logic [1:0]     txSync_q;
    logic           txPrev_q;
    logic [1:0]     clkSync_q;
    logic           timerClk;
    logic [15:0]    syncDelay;
    logic [14:0]    timerDivisor;
    logic           triggerHit;
    logic           txFall;

    function automatic logic regWrite(input uts_reg_req_t r, input logic [7:0] a);
        regWrite = r.write && (r.addr == a);
    endfunction

    assign syncDelay    = {delayHigh_q, delayLow_q};
    assign timerDivisor = {timerHigh_q[6:0], timerLow_q};

    // Every uart watches the same global byte; match upper nibble and select
    assign triggerHit = regWrite(regReq, GLOBAL_COMMAND_ADDR)
                     && (regReq.wdata[7:4] == TRIGGER_CMD_BASE)
                     && (regReq.wdata[3:0] == ctrl_q.triggerSelect)
                     && ctrl_q.syncEnable;

    // =========================================================
    // Register writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q      <= REG_RESET_VALUE;
            delayLow_q  <= REG_RESET_VALUE;
            delayHigh_q <= REG_RESET_VALUE;
            timerLow_q  <= REG_RESET_VALUE;
            timerHigh_q <= REG_RESET_VALUE;
        end else begin
            if (regWrite(regReq, TX_SYNC_CONTROL_ADDR)) begin
                ctrl_q <= regReq.wdata;
            end
            if (regWrite(regReq, SYNC_DELAY_LOW_ADDR)) begin
                delayLow_q <= regReq.wdata;
            end
            if (regWrite(regReq, SYNC_DELAY_HIGH_ADDR)) begin
                delayHigh_q <= regReq.wdata;
            end
            if (regWrite(regReq, TIMER_DIV_LOW_ADDR)) begin
                timerLow_q <= regReq.wdata;
            end
            if (regWrite(regReq, TIMER_DIV_HIGH_ADDR)) begin
                timerHigh_q <= regReq.wdata;
            end
        end
    end

    // =========================================================
    // Read data, registered; unmapped offsets read zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regReq.read) begin
            case (regReq.addr)
                TX_SYNC_CONTROL_ADDR:  regRdata <= ctrl_q;
                SYNC_DELAY_LOW_ADDR:   regRdata <= delayLow_q;
                SYNC_DELAY_HIGH_ADDR:  regRdata <= delayHigh_q;
                TIMER_DIV_LOW_ADDR:    regRdata <= timerLow_q;
                TIMER_DIV_HIGH_ADDR:   regRdata <= timerHigh_q;
                SILICON_REVISION_ADDR: regRdata <= REVISION_ID;
                default:               regRdata <= 8'h00;
            endcase
        end
    end

    // =========================================================
    // Transmit line watch; tx pin comes from pad, so two flops first
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txSync_q <= 2'b11;
            txPrev_q <= 1'b1;
        end else begin
            txSync_q <= {txSync_q[0], txLineIn};
            txPrev_q <= txSync_q[1];
        end
    end
    assign txFall = txPrev_q && !txSync_q[1];

    // =========================================================
    // Sync state machine
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q    <= UTS_IDLE;
            delayCnt_q <= DELAY_ZERO;
        end else if (!ctrl_q.syncEnable) begin
            state_q    <= UTS_IDLE;
            delayCnt_q <= DELAY_ZERO;
        end else begin
            case (state_q)
                UTS_IDLE: begin
                    if (triggerHit && ctrl_q.triggerDelayEnable
                        && syncDelay != DELAY_ZERO) begin
                        state_q    <= UTS_DELAY;
                        delayCnt_q <= syncDelay;
                    end else if (triggerHit) begin
                        state_q <= UTS_ARMED;
                    end
                end
                UTS_DELAY: begin
                    // Counts in bit intervals from the baud generator
                    if (bitTick) begin
                        if (delayCnt_q == 16'h0001) begin
                            state_q <= UTS_ARMED;
                        end
                        delayCnt_q <= delayCnt_q - 16'h0001;
                    end
                end
                UTS_ARMED: begin
                    // Arming held until data is queued
                    if (!txFifoEmpty) begin
                        state_q <= UTS_RUNNING;
                    end
                end
                UTS_RUNNING: begin
                    if (ctrl_q.autoTxDisable && txFifoEmpty && txSync_q[1]) begin
                        state_q <= UTS_IDLE;
                    end
                end
                default: state_q <= UTS_IDLE;
            endcase
        end
    end

    // =========================================================
    // Transmitter disable control towards the mode register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txDisableForce   <= 1'b0;
            txDisableRelease <= 1'b0;
            txRun            <= 1'b0;
        end else begin
            txDisableForce <= (regWrite(regReq, TX_SYNC_CONTROL_ADDR)
                               && regReq.wdata[SYNC_ENABLE_BIT])
                           || (state_q == UTS_RUNNING && ctrl_q.autoTxDisable
                               && txFifoEmpty && txSync_q[1]);
            txDisableRelease <= (state_q == UTS_ARMED) && !txFifoEmpty;
            txRun            <= (state_q == UTS_RUNNING);
        end
    end

    // =========================================================
    // Start-of-transmission marker
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            syncStarted <= 1'b0;
            syncState   <= 2'b00;
        end else begin
            syncStarted <= txFall && (state_q == UTS_RUNNING);
            syncState   <= state_q;
        end
    end

    // =========================================================
    // Clock replica routing; replica is foreign so it is synchronised
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clkSync_q    <= 2'b00;
            sysClkGpio   <= 1'b0;
            sysClkGpioEn <= 1'b0;
        end else begin
            clkSync_q    <= {clkSync_q[0], sysClkReplica};
            sysClkGpio   <= clkSync_q[1];
            sysClkGpioEn <= ctrl_q.sysclkGpioRoute;
        end
    end

    // =========================================================
    // Timer clock, paced by the fractional generator tick
    uts_timer_div u_timer (
        .clock    (clock),
        .rst      (rst),
        .baudTick (baudTick),
        .divisor  (timerDivisor),
        .timerClk (timerClk)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timerGpio   <= 1'b0;
            timerGpioEn <= 1'b0;
        end else begin
            timerGpio   <= timerClk;
            timerGpioEn <= timerHigh_q[TIMER_GPIO_ROUTE_BIT];
        end
    end

endmodule // uts_tx_sync_timer

// >>> core/uts_pkg.sv
// Package: register map, field positions, reset values and commands of the tx sync timer
package uts_pkg;

    // =========================================================
    // Register offsets
    localparam logic [7:0] TX_SYNC_CONTROL_ADDR   = 8'h20;
    localparam logic [7:0] SYNC_DELAY_LOW_ADDR    = 8'h21;
    localparam logic [7:0] SYNC_DELAY_HIGH_ADDR   = 8'h22;
    localparam logic [7:0] TIMER_DIV_LOW_ADDR     = 8'h23;
    localparam logic [7:0] TIMER_DIV_HIGH_ADDR    = 8'h24;
    localparam logic [7:0] SILICON_REVISION_ADDR  = 8'h25;
    localparam logic [7:0] GLOBAL_COMMAND_ADDR    = 8'h1f;

    // =========================================================
    // Field positions
    localparam int SYSCLK_GPIO_ROUTE_BIT  = 7;
    localparam int AUTO_TX_DISABLE_BIT    = 6;
    localparam int TRIGGER_DELAY_BIT      = 5;
    localparam int SYNC_ENABLE_BIT        = 4;
    localparam int TIMER_GPIO_ROUTE_BIT   = 7;

    // =========================================================
    // Reset values and commands
    localparam logic [7:0] REG_RESET_VALUE   = 8'h00;
    localparam logic [3:0] TRIGGER_CMD_BASE  = 4'he;
    localparam logic [9:0] TIMER_PRESCALE    = 10'h1ff;
    localparam logic [15:0] DELAY_ZERO       = 16'h0000;
    localparam logic [14:0] TIMER_ZERO       = 15'h0000;

    // =========================================================
    // Types
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } uts_reg_req_t;

    typedef struct packed {
        logic sysclkGpioRoute;
        logic autoTxDisable;
        logic triggerDelayEnable;
        logic syncEnable;
        logic [3:0] triggerSelect;
    } uts_sync_ctrl_t;

    typedef enum logic [1:0] {
        UTS_IDLE    = 2'b00,
        UTS_ARMED   = 2'b01,
        UTS_DELAY   = 2'b10,
        UTS_RUNNING = 2'b11
    } uts_state_t;

endpackage : uts_pkg

// >>> core/uts_timer_div.sv
// Low-frequency timer clock divider with 50% duty output
`timescale 1ns/1ns
module uts_timer_div (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        baudTick,
    input  wire logic [14:0] divisor,
    output logic             timerClk
);
    import uts_pkg::*;

    logic [9:0]  preCnt_q;
    logic [14:0] divCnt_q;

    // =========================================================
    // Half period is 512 x divisor uart clocks, so a full period is 1024 x divisor
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            preCnt_q <= 10'h000;
            divCnt_q <= 15'h0000;
            timerClk <= 1'b0;
        end else if (divisor == TIMER_ZERO) begin
            preCnt_q <= 10'h000;
            divCnt_q <= 15'h0000;
            timerClk <= 1'b0;
        end else if (baudTick) begin
            if (preCnt_q == TIMER_PRESCALE) begin
                preCnt_q <= 10'h000;
                if (divCnt_q >= divisor - 15'h0001) begin
                    divCnt_q <= 15'h0000;
                    timerClk <= ~timerClk;
                end else begin
                    divCnt_q <= divCnt_q + 15'h0001;
                end
            end else begin
                preCnt_q <= preCnt_q + 10'h001;
            end
        end
    end
endmodule // uts_timer_div

// >>> bench/uts_host_model.sv
// Host model: register bus cycles and broadcast trigger commands
`timescale 1ns/1ns
module uts_host_model (
    input  wire logic             clock,
    input  wire logic [7:0]       regRdata,
    output uts_pkg::uts_reg_req_t regReq
);
    import uts_pkg::*;
    initial regReq = '0;
    // ============================================================
    // Bus cycles: one-cycle request; released fields are inverted
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clock);
        regReq <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clock);
        regReq <= '{1'b0, 1'b0, ~a, 8'hff};
        @(negedge clock);
        d = regRdata;
    endtask
    task automatic ext();
        wr(GLOBAL_COMMAND_ADDR, 8'hce);
    endtask
    task automatic trig(input logic [7:0] code);
        wr(GLOBAL_COMMAND_ADDR, code);
    endtask
endmodule // uts_host_model

// >>> bench/uts_tx_sync_timer_sva.sv
// Checker: sync state, route enables and timer stop seen at the ports
`timescale 1ns/1ns
module uts_tx_sync_timer_sva (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire uts_pkg::uts_reg_req_t regReq,
    input  wire logic                  txFifoEmpty,
    input  wire logic                  txDisableForce,
    input  wire logic                  txRun,
    input  wire logic                  syncStarted,
    input  wire logic                  sysClkGpioEn,
    input  wire logic                  timerGpio,
    input  wire logic                  timerGpioEn,
    input  wire logic [1:0]            syncState
);
    import uts_pkg::*;
    // ============================================================
    // Shadow registers, updated at the same edge as the design's
    logic [7:0]  ctlQ;
    logic [15:0] tmrQ;
    wire cmdW = regReq.write && regReq.addr == GLOBAL_COMMAND_ADDR;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) ctlQ <= 8'h00;
        else if (regReq.write && regReq.addr == TX_SYNC_CONTROL_ADDR) ctlQ <= regReq.wdata;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) tmrQ <= 16'h0000;
        else if (regReq.write && regReq.addr == TIMER_DIV_LOW_ADDR) tmrQ[7:0] <= regReq.wdata;
        else if (regReq.write && regReq.addr == TIMER_DIV_HIGH_ADDR) tmrQ[15:8] <= regReq.wdata;
    end
    // ============================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_match;
        cmdW && regReq.wdata == {TRIGGER_CMD_BASE, ctlQ[3:0]} && ctlQ[4] && !ctlQ[5];
    endsequence
    a_trig_arms: assert property (
        s_match ##0 syncState == UTS_IDLE |-> ##2 syncState == UTS_ARMED) else $error("no arm");
    a_sync_off_idle: assert property (
        cmdW && !ctlQ[4] && syncState == UTS_IDLE |-> ##2 syncState == UTS_IDLE)
        else $error("armed");
    // State output lags the state register by one clock
    a_armed_hold: assert property (
        syncState == UTS_ARMED && $past(txFifoEmpty) && !$past(regReq.write, 2)
        |=> syncState == UTS_ARMED) else $error("arming lost");
    a_start_direct: assert property (
        syncState == UTS_ARMED && !$past(txFifoEmpty) && !ctlQ[5] && !$past(regReq.write, 2)
        |=> syncState == UTS_RUNNING) else $error("no start");
    a_run_flag: assert property (
        syncState == UTS_RUNNING |-> txRun) else $error("run flag low");
    a_force_disable: assert property (
        regReq.write && regReq.addr == TX_SYNC_CONTROL_ADDR && regReq.wdata[SYNC_ENABLE_BIT]
        |-> ##[1:2] txDisableForce) else $error("no disable force");
    a_start_pulse: assert property (
        syncStarted |-> txRun ##1 !syncStarted) else $error("bad start pulse");
    a_timer_stop: assert property (
        (tmrQ[14:0] == TIMER_ZERO) [*4] |-> $stable(timerGpio)) else $error("timer runs");
    a_clk_route: assert property (
        (!ctlQ[SYSCLK_GPIO_ROUTE_BIT]) [*3] |-> !sysClkGpioEn) else $error("clock routed");
    a_tmr_route: assert property (
        (!tmrQ[TIMER_GPIO_ROUTE_BIT + 8]) [*3] |-> !timerGpioEn) else $error("timer routed");
endmodule // uts_tx_sync_timer_sva
bind uts_tx_sync_timer uts_tx_sync_timer_sva u_sva (.clock(clock), .rst(rst), .regReq(regReq),
    .txFifoEmpty(txFifoEmpty), .txDisableForce(txDisableForce), .txRun(txRun),
    .syncStarted(syncStarted), .sysClkGpioEn(sysClkGpioEn), .timerGpio(timerGpio),
    .timerGpioEn(timerGpioEn), .syncState(syncState));

// >>> bench/tb_uts_tx_sync_timer.sv
// Testbench: registers, trigger decode, delay and timer clock
`timescale 1ns/1ns
module tb_uts_tx_sync_timer;
    import uts_pkg::*;
    localparam logic [7:0] REV = 8'h3c;  // Arbitrary value
    logic clock = 1'b0, rst = 1'b1, bitTick = 1'b0, txFifoEmpty = 1'b1, txLineIn = 1'b1;
    logic sysClkReplica = 1'b0, txDisableForce, txDisableRelease, txRun, syncStarted;
    logic sysClkGpio, sysClkGpioEn, timerGpio, timerGpioEn, baudTick = 1'b0;
    logic [7:0] regRdata, d;
    logic [1:0] syncState, bc = 2'd0;
    uts_reg_req_t regReq;
    int n_errors = 0, n_checks = 0, cyc = 0, lat, ref0, k;
    uts_host_model host (.clock(clock), .regRdata(regRdata), .regReq(regReq));
    uts_tx_sync_timer #(.REVISION_ID(REV)) dut (.clock(clock), .rst(rst), .regReq(regReq),
        .baudTick(baudTick), .bitTick(bitTick), .txFifoEmpty(txFifoEmpty), .txLineIn(txLineIn),
        .sysClkReplica(sysClkReplica), .regRdata(regRdata), .txDisableForce(txDisableForce),
        .txDisableRelease(txDisableRelease), .txRun(txRun), .syncStarted(syncStarted),
        .sysClkGpio(sysClkGpio), .sysClkGpioEn(sysClkGpioEn), .timerGpio(timerGpio),
        .timerGpioEn(timerGpioEn), .syncState(syncState));
    // ============================================================
    // Clock, bit interval of four cycles, timeout
    initial forever #20 clock = ~clock;
    always @(posedge clock) begin
        bc <= bc + 2'd1;
        bitTick <= (bc == 2'd3);
        baudTick <= bc[0];
        sysClkReplica <= bc[1];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    // ============================================================
    // Helpers
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic trigLat(input logic [7:0] code, output int n);
        do @(negedge clock); while (bc != 2'd0);
        host.trig(code);
        n = 0;
        while (txRun !== 1'b1 && n < 1200) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic goIdle();
        @(posedge clock);
        txFifoEmpty <= 1'b1;
        repeat (4) @(negedge clock);
        chk("idle", UTS_IDLE, syncState);
    endtask
    task automatic halfPer(output int n);
        logic v;
        v = timerGpio;
        n = 0;
        while (timerGpio === v && n < 3000) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ============================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        host.ext();
        for (int a = 0; a < 5; a++) begin
            host.rd(TX_SYNC_CONTROL_ADDR + a[7:0], d);
            chk("reset value", 8'h00, d);
        end
        host.wr(SILICON_REVISION_ADDR, ~REV);
        host.rd(SILICON_REVISION_ADDR, d);
        chk("revision", REV, d);
        host.wr(8'h30, 8'h77);
        host.rd(8'h30, d);
        chk("unmapped", 8'h00, d);
        for (int a = 1; a < 5; a++) begin
            host.wr(TX_SYNC_CONTROL_ADDR + a[7:0], 8'h3c ^ a[7:0]);
            host.rd(TX_SYNC_CONTROL_ADDR + a[7:0], d);
            chk("readback", 8'h3c ^ a[7:0], d);
        end
        // No-delay and zero-delay triggers must start alike
        host.wr(SYNC_DELAY_LOW_ADDR, 8'h00);
        host.wr(SYNC_DELAY_HIGH_ADDR, 8'h00);
        txFifoEmpty <= 1'b0;
        for (int n = 0; n < 16; n++) begin
            host.wr(TX_SYNC_CONTROL_ADDR, 8'h00);
            host.trig(8'he0 | n[7:0]);
            repeat (2) @(negedge clock);
            chk("sync off", UTS_IDLE, syncState);
            host.wr(TX_SYNC_CONTROL_ADDR, (n[0] ? 8'hf0 : 8'hd0) | n[7:0]);
            host.trig(8'he0 | ((n[7:0] + 8'd1) & 8'h0f));
            repeat (2) @(negedge clock);
            chk("other code", UTS_IDLE, syncState);
            trigLat(8'he0 | n[7:0], lat);
            if (n == 0) ref0 = lat;
            chk("latency", ref0[15:0], lat[15:0]);
            chk("clock route", 1'b1, sysClkGpioEn);
            repeat (n % 4) @(negedge clock);
            d[0] = sysClkReplica;
            repeat (3) @(negedge clock);
            chk("clock copy", d[0], sysClkGpio);
            @(posedge clock);
            txLineIn <= 1'b0;
            k = 0;
            while (syncStarted !== 1'b1 && k < 8) begin
                @(negedge clock);
                k++;
            end
            chk("start edge", 1'b1, syncStarted);
            @(posedge clock);
            txLineIn <= 1'b1;
            goIdle();
            @(posedge clock);
            txFifoEmpty <= 1'b0;
            repeat (8) @(negedge clock);
            chk("waits for trigger", 1'b0, txRun);
        end
        host.wr(TX_SYNC_CONTROL_ADDR, 8'h50);
        txFifoEmpty <= 1'b1;
        trigLat(8'he0, lat);
        chk("armed empty", UTS_ARMED, syncState);
        @(posedge clock);
        txFifoEmpty <= 1'b0;
        repeat (2) @(negedge clock);
        chk("release", 1'b1, txDisableRelease);
        repeat (2) @(negedge clock);
        chk("run after data", 1'b1, txRun);
        goIdle();
        // Delay scales by four cycles per bit interval
        host.wr(TX_SYNC_CONTROL_ADDR, 8'h70);
        host.wr(SYNC_DELAY_LOW_ADDR, 8'h03);
        txFifoEmpty <= 1'b0;
        trigLat(8'he0, ref0);
        goIdle();
        host.wr(SYNC_DELAY_HIGH_ADDR, 8'h01);
        txFifoEmpty <= 1'b0;
        trigLat(8'he0, lat);
        chk("delay", ref0[15:0] + 16'd1024, lat[15:0]);
        goIdle();
        for (int v = 1; v < 3; v++) begin
            host.wr(TIMER_DIV_LOW_ADDR, v[7:0]);
            host.wr(TIMER_DIV_HIGH_ADDR, 8'h80);
            halfPer(lat);
            halfPer(lat);
            // 512 uart ticks per count, one tick every two clocks
            chk("timer high", 16'd1024 * v[15:0], lat[15:0]);
            halfPer(lat);
            chk("timer low", 16'd1024 * v[15:0], lat[15:0]);
            chk("timer route", 1'b1, timerGpioEn);
        end
        host.wr(TIMER_DIV_LOW_ADDR, 8'h00);
        host.wr(TIMER_DIV_HIGH_ADDR, 8'h00);
        repeat (4) @(negedge clock);
        d[0] = timerGpio;
        repeat (1100) @(negedge clock);
        chk("timer stopped", d[0], timerGpio);
        stop_test();
    end
endmodule // tb_uts_tx_sync_timer
